// File: logic/hsct_top.sv
/*
  Heatseal cycle timer: starting delay, heating phase, cooling phase,
  relay and phase indication, with an APB register port.
  Assumes start, reset and manual key come from pins; band and set
  temperatures (deg C) come from logic on the same clock.
*/
// Notes on behaviour
// R1 - time control off, on, or monitored start
// R2 - start launches cycle; reset aborts it
// R3 - monitored mode aborts when start drops early
// R4 - cycle is delay, heating, cooling, relay
// R5 - manual key only heats, never launches cycle
// R6 - countdown with heat marker, then cool marker
// R7 - relay icon shown exactly while contact closed
// R8 - starting delay 0 to 9.9 s, default 0
// R9 - fixed seal time 0 to 99.9 s, default 1
// R10 - external mode: seal lasts while start active
// R11 - absolute cooling ends below cooling temperature
// R12 - relative cooling ends at percent of setpoint
// R13 - timed cooling ends after set time
// R14 - changing cooling mode resets cooling value
// R15 - absolute cooling temp 50 up to maximum
// R16 - relative cooling 40 to 100 percent, default 40
// R17 - timed cooling 0 to 99.9 s, default 10
// R18 - seal time may wait for 95 percent
// R19 - abort stops heat, clears marker, returns idle
`timescale 1ns/10ps
`default_nettype none

module hsct_top
  import hsct_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // clocking
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // machine pins
  input  wire logic        startIn,
  input  wire logic        resetIn,
  input  wire logic        manualHeatKey,
  // temperatures from the control loop
  input  wire logic [9:0]  tempAct,
  input  wire logic [9:0]  tempSet,
  // indications
  output var  logic        heatOn,
  output var  logic [1:0]  phaseMark,
  output var  logic [9:0]  countdown,
  output var  logic        outputRelay,
  output var  logic        relayIcon
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] rstSync_ff;
  logic       rst_n;
  logic       startS, resetS, keyS;
  logic       tick, tickClr;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_ff <= 2'b00;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rst_n = rstSync_ff[1];

  hsct_sync #(.W(3)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .din   ({startIn, resetIn, manualHeatKey}),
    .dout  ({startS, resetS, keyS})
  );

  hsct_tick #(.CYC(TICK_CYCLES)) u_tick (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .clear (tickClr),
    .tick  (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register file
  hsct_cfg_t   cfg_ff, nxt_cfg;
  logic [6:0]  delay_ff, nxt_delay;
  logic [9:0]  seal_ff, nxt_seal;
  logic [9:0]  cool_ff, nxt_cool;
  logic [9:0]  maxT_ff, nxt_maxT;
  logic [31:0] nxt_prdata;
  logic        nxt_pready, nxt_pslverr;
  logic        apbDone, mapped;
  logic [31:0] statWord;
  hsct_cfg_t   wCfg;

  function automatic logic [9:0] clampv(input logic [9:0] v,
      input logic [9:0] lo, input logic [9:0] hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampv

  function automatic logic [9:0] coolDefault(input hsct_cmode_t m);
    unique case (m)
      CM_ABS:  coolDefault = MIN_COOLABS;                 // see R15
      CM_REL:  coolDefault = MIN_COOLREL;                 // see R16
      default: coolDefault = RST_COOLTIME;                // see R17
    endcase
  endfunction : coolDefault

  assign apbDone = psel & penable & pready;
  assign mapped  = (paddr <= OFS_STAT) && (paddr[1:0] == 2'b00);

  always_comb begin
    wCfg.tmode       = hsct_tmode_t'(pwdata[CTRL_TM_LSB +: 2]);
    wCfg.extDur      = pwdata[CTRL_EXT_BIT];
    wCfg.cmode       = hsct_cmode_t'(pwdata[CTRL_CM_LSB +: 2]);
    wCfg.startOnTemp = pwdata[CTRL_SOT_BIT];
    wCfg.relayFn     = hsct_relay_t'(pwdata[CTRL_RLY_LSB +: 3]);
    // illegal mode codes fall back to the factory choice; an illegal relay code falls back to off
    if (wCfg.tmode == 2'b11) begin
      wCfg.tmode = TM_OFF;                                // see R1
    end
    if (wCfg.cmode == 2'b11) begin
      wCfg.cmode = CM_ABS;
    end
    if (wCfg.relayFn > RF_EOC) begin
      wCfg.relayFn = RF_OFF;
    end
  end

  always_comb begin
    nxt_cfg   = cfg_ff;
    nxt_delay = delay_ff;
    nxt_seal  = seal_ff;
    nxt_cool  = cool_ff;
    nxt_maxT  = maxT_ff;
    if (apbDone && pwrite && mapped) begin
      unique case (paddr)
        OFS_CTRL: begin
          nxt_cfg = wCfg;
          if (wCfg.cmode != cfg_ff.cmode) begin
            nxt_cool = coolDefault(wCfg.cmode);           // see R14
          end
        end
        OFS_DELAY: nxt_delay = (pwdata[6:0] > MAX_DELAY) ? MAX_DELAY
                                                         : pwdata[6:0]; // see R8
        OFS_SEAL:  nxt_seal = clampv(pwdata[9:0], 10'h000, MAX_SEAL); // see R9
        OFS_COOL: begin
          unique case (cfg_ff.cmode)
            CM_ABS:  nxt_cool = clampv(pwdata[9:0], MIN_COOLABS,
                                       maxT_ff);          // see R15
            CM_REL:  nxt_cool = clampv(pwdata[9:0], MIN_COOLREL,
                                       MAX_COOLREL);      // see R16
            default: nxt_cool = clampv(pwdata[9:0], 10'h000,
                                       MAX_COOLTIME);     // see R17
          endcase
        end
        OFS_MAXT: begin
          nxt_maxT = (pwdata[9:0] < MIN_COOLABS) ? MIN_COOLABS
                                                 : pwdata[9:0];
          // a lowered maximum pulls the absolute cooling value along
          if (cfg_ff.cmode == CM_ABS && cool_ff > nxt_maxT) begin
            nxt_cool = nxt_maxT;                          // see R15
          end
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    nxt_pready  = psel & penable & ~pready;
    nxt_pslverr = nxt_pready & ~mapped;
    nxt_prdata  = prdata;
    if (nxt_pready) begin
      nxt_prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          OFS_CTRL: begin
            nxt_prdata[CTRL_TM_LSB +: 2]  = cfg_ff.tmode;
            nxt_prdata[CTRL_EXT_BIT]      = cfg_ff.extDur;
            nxt_prdata[CTRL_CM_LSB +: 2]  = cfg_ff.cmode;
            nxt_prdata[CTRL_SOT_BIT]      = cfg_ff.startOnTemp;
            nxt_prdata[CTRL_RLY_LSB +: 3] = cfg_ff.relayFn;
          end
          OFS_DELAY: nxt_prdata[6:0] = delay_ff;
          OFS_SEAL:  nxt_prdata[9:0] = seal_ff;
          OFS_COOL:  nxt_prdata[9:0] = cool_ff;
          OFS_MAXT:  nxt_prdata[9:0] = maxT_ff;
          OFS_STAT:  nxt_prdata      = statWord;
          default:   nxt_prdata      = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff   <= RST_CFG;
      delay_ff <= RST_DELAY;
      seal_ff  <= RST_SEAL;
      cool_ff  <= MIN_COOLABS;
      maxT_ff  <= RST_MAXT;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else if (ce) begin
      cfg_ff   <= nxt_cfg;
      delay_ff <= nxt_delay;
      seal_ff  <= nxt_seal;
      cool_ff  <= nxt_cool;
      maxT_ff  <= nxt_maxT;
      prdata   <= nxt_prdata;
      pready   <= nxt_pready;
      pslverr  <= nxt_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer
  hsct_state_t state_ff, nxt_state;
  logic [9:0]  cnt_ff, nxt_cnt;
  logic [2:0]  eoc_ff, nxt_eoc;
  logic        startD_ff, reached_ff, nxt_reached;
  logic        startRise, hot, coolDone, abort, monitored;
  logic [19:0] actScaled, setReach, setCool;
  logic        nxt_heat, nxt_relay;
  hsct_phase_t nxt_phase;
  logic [9:0]  nxt_countdown;

  assign startRise = startS & ~startD_ff;
  assign actScaled = 20'(tempAct) * 20'(PCT_FULL);
  assign setReach  = 20'(tempSet) * 20'(REACH_PCT);
  assign setCool   = 20'(tempSet) * 20'(cool_ff);
  assign hot       = actScaled >= setReach;               // see R18
  // external mode ends heating by dropping start, so it is not monitored
  assign monitored = (cfg_ff.tmode == TM_MON) && !cfg_ff.extDur;
  assign abort     = (state_ff != ST_IDLE)
                     && (resetS || (monitored && !startS)); // see R2 R3

  always_comb begin
    unique case (cfg_ff.cmode)
      CM_ABS:  coolDone = tempAct < cool_ff;              // see R11
      CM_REL:  coolDone = actScaled <= setCool;           // see R12
      default: coolDone = cnt_ff >= cool_ff;              // see R13
    endcase
  end

  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = tick ? cnt_ff + 10'h001 : cnt_ff;
    nxt_eoc     = (tick && eoc_ff != 3'h0) ? eoc_ff - 3'h1 : eoc_ff;
    nxt_reached = reached_ff | (hot && state_ff != ST_IDLE);
    tickClr     = 1'b0;
    // a new start drops the pulse, but a cycle ending now still sets it
    if (startRise) begin
      nxt_eoc = 3'h0;
    end
    unique case (state_ff)
      ST_IDLE: begin
        nxt_reached = 1'b0;
        if (startRise && cfg_ff.tmode != TM_OFF && !resetS) begin
          nxt_state = ST_DELAY;                           // see R1 R2 R4
          nxt_cnt   = 10'h000;
          tickClr   = 1'b1;
        end
      end
      ST_DELAY: begin
        if (cnt_ff >= 10'(delay_ff)) begin                // see R8
          nxt_state = (cfg_ff.startOnTemp && !cfg_ff.extDur)
                      ? ST_WAITT : ST_HEAT;               // see R18
          nxt_cnt   = 10'h000;
          tickClr   = 1'b1;
        end
      end
      ST_WAITT: begin
        if (hot) begin
          nxt_state = ST_HEAT;                            // see R18
          nxt_cnt   = 10'h000;
          tickClr   = 1'b1;
        end
      end
      ST_HEAT: begin
        if (cfg_ff.extDur ? !startS : cnt_ff >= seal_ff) begin // see R9 R10
          nxt_state = ST_COOL;                            // see R4
          nxt_cnt   = 10'h000;
          tickClr   = 1'b1;
        end
      end
      ST_COOL: begin
        if (coolDone) begin
          nxt_state = ST_IDLE;
          nxt_eoc   = EOC_TICKS;
          tickClr   = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (abort) begin
      nxt_state = ST_IDLE;                                // see R19
      nxt_eoc   = 3'h0;
    end
  end

  // indications follow the next state so they change with it
  always_comb begin
    nxt_heat      = 1'b0;
    nxt_phase     = PH_NONE;
    nxt_countdown = 10'h000;
    nxt_relay     = 1'b0;
    if (nxt_state == ST_IDLE) begin
      // with time control off, start gives plain heating only
      nxt_heat = keyS | (cfg_ff.tmode == TM_OFF && startS && !resetS); // see R5
    end
    if (nxt_state == ST_WAITT || nxt_state == ST_HEAT) begin
      nxt_heat  = 1'b1;
      nxt_phase = PH_HEAT;                                // see R6
      if (!cfg_ff.extDur) begin
        nxt_countdown = (nxt_state == ST_HEAT) ? seal_ff - nxt_cnt
                                               : seal_ff;
      end
    end
    if (nxt_state == ST_COOL) begin
      nxt_phase = PH_COOL;                                // see R6
    end
    unique case (cfg_ff.relayFn)
      RF_START: nxt_relay = nxt_state != ST_IDLE;
      RF_TEMP:  nxt_relay = nxt_reached && nxt_state != ST_IDLE;
      RF_COOL:  nxt_relay = nxt_state == ST_COOL;
      RF_EOC:   nxt_relay = nxt_eoc != 3'h0;
      default:  nxt_relay = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= 10'h000;
      eoc_ff      <= 3'h0;
      startD_ff   <= 1'b0;
      reached_ff  <= 1'b0;
      heatOn      <= 1'b0;
      phaseMark   <= PH_NONE;
      countdown   <= 10'h000;
      outputRelay <= 1'b0;
      relayIcon   <= 1'b0;
    end else if (ce) begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      eoc_ff      <= nxt_eoc;
      startD_ff   <= startS;
      reached_ff  <= nxt_reached;
      heatOn      <= nxt_heat;
      phaseMark   <= nxt_phase;
      countdown   <= nxt_countdown;
      outputRelay <= nxt_relay;
      relayIcon   <= nxt_relay;                           // see R7
    end
  end

  always_comb begin
    statWord = 32'h0000_0000;
    statWord[STAT_ST_LSB +: 3]  = state_ff;
    statWord[STAT_PH_LSB +: 2]  = phaseMark;
    statWord[STAT_RLY_BIT]      = outputRelay;
    statWord[STAT_HEAT_BIT]     = heatOn;
    statWord[STAT_CD_LSB +: 10] = countdown;
  end

endmodule : hsct_top

`default_nettype wire

// File: pkg/hsct_pkg.sv
/*
  Constants, enumerations and carrier types for the heatseal cycle timer.
  Assumes a 20 MHz system clock and a 32-bit APB register port.
*/
`default_nettype none

package hsct_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_DELAY = 8'h04;
  localparam logic [7:0] OFS_SEAL  = 8'h08;
  localparam logic [7:0] OFS_COOL  = 8'h0C;
  localparam logic [7:0] OFS_MAXT  = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;

  // control register fields
  localparam int CTRL_TM_LSB   = 0;
  localparam int CTRL_EXT_BIT  = 2;
  localparam int CTRL_CM_LSB   = 4;
  localparam int CTRL_SOT_BIT  = 6;
  localparam int CTRL_RLY_LSB  = 8;

  // status register fields
  localparam int STAT_ST_LSB   = 0;
  localparam int STAT_PH_LSB   = 4;
  localparam int STAT_RLY_BIT  = 6;
  localparam int STAT_HEAT_BIT = 7;
  localparam int STAT_CD_LSB   = 16;

  // values after reset and setting limits (times in 0.1 s units)
  localparam logic [6:0] RST_DELAY    = 7'h00;
  localparam logic [6:0] MAX_DELAY    = 7'h63;
  localparam logic [9:0] RST_SEAL     = 10'h00A;
  localparam logic [9:0] MAX_SEAL     = 10'h3E7;
  localparam logic [9:0] MIN_COOLABS  = 10'h032;
  localparam logic [9:0] MIN_COOLREL  = 10'h028;
  localparam logic [9:0] MAX_COOLREL  = 10'h064;
  localparam logic [9:0] RST_COOLTIME = 10'h064;
  localparam logic [9:0] MAX_COOLTIME = 10'h3E7;
  localparam logic [9:0] RST_MAXT     = 10'h12C;
  localparam logic [6:0] REACH_PCT    = 7'h5F;
  localparam logic [6:0] PCT_FULL     = 7'h64;

  // timing
  localparam int CLK_NS    = 50;
  localparam int TICK_NS   = 100_000_000;
  localparam int TICK_CYC  = TICK_NS / CLK_NS;
  localparam int EOC_NS    = 500_000_000;
  localparam logic [2:0] EOC_TICKS = 3'(EOC_NS / TICK_NS);

  typedef enum logic [1:0] {
    TM_OFF = 2'b00,
    TM_ON  = 2'b01,
    TM_MON = 2'b10
  } hsct_tmode_t;

  typedef enum logic [1:0] {
    CM_ABS  = 2'b00,
    CM_REL  = 2'b01,
    CM_TIME = 2'b10
  } hsct_cmode_t;

  typedef enum logic [2:0] {
    RF_OFF   = 3'b000,
    RF_START = 3'b001,
    RF_TEMP  = 3'b010,
    RF_COOL  = 3'b011,
    RF_EOC   = 3'b100
  } hsct_relay_t;

  typedef enum logic [1:0] {
    PH_NONE = 2'b00,
    PH_HEAT = 2'b01,
    PH_COOL = 2'b10
  } hsct_phase_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DELAY = 3'b001,
    ST_WAITT = 3'b010,
    ST_HEAT  = 3'b011,
    ST_COOL  = 3'b100
  } hsct_state_t;

  typedef struct packed {
    hsct_tmode_t tmode;
    logic        extDur;
    hsct_cmode_t cmode;
    logic        startOnTemp;
    hsct_relay_t relayFn;
  } hsct_cfg_t;

  localparam hsct_cfg_t RST_CFG = '{TM_OFF, 1'b0, CM_ABS, 1'b1, RF_TEMP};

endpackage : hsct_pkg

`default_nettype wire

// File: logic/hsct_sync.sv
/*
  Two-stage synchroniser for a group of pin levels.
  Assumes the inputs are asynchronous levels; only the second stage is read.
*/
`timescale 1ns/10ps
`default_nettype none

module hsct_sync #(
  parameter int W = 3
) (
  // clocking
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // levels
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      dout    <= '0;
    end else if (ce) begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end

endmodule : hsct_sync

`default_nettype wire

// File: logic/hsct_tick.sv
/*
  Tenth-second tick generator with restart.
  Assumes clear is a same-clock pulse; a tick lands CYC + 1 cycles after clear.
*/
`timescale 1ns/10ps
`default_nettype none

module hsct_tick #(
  parameter int CYC = 2_000_000
) (
  // clocking
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic ce,
  // control
  input  wire logic clear,
  output var  logic tick
);

  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          nxt_tick;

  always_comb begin
    nxt_cnt  = cnt_ff + CW'(1);
    nxt_tick = 1'b0;
    if (clear) begin
      nxt_cnt = '0;
    end else if (cnt_ff == LAST) begin
      nxt_cnt  = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      tick   <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      tick   <= nxt_tick;
    end
  end

endmodule : hsct_tick

`default_nettype wire

// File: tb/hsct_monitor.sv
/* Port checker for the heatseal cycle timer.
   Assumes ce is held high, so pins reach the sequencer two edges late. */
`timescale 1ns/10ps
`default_nettype none
module hsct_monitor
  import hsct_pkg::*;
(
  // clocking
  input wire logic       clock,
  input wire logic       arst_n,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // pins and indications
  input wire logic       resetIn,
  input wire logic       heatOn,
  input wire logic [1:0] phaseMark,
  input wire logic [9:0] countdown,
  input wire logic       outputRelay,
  input wire logic       relayIcon
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////
  property p_icon; relayIcon == outputRelay; endproperty
  a_icon: assert property (p_icon) else $error("icon differs");
  property p_heatph; phaseMark == PH_HEAT |-> heatOn; endproperty
  a_heatph: assert property (p_heatph) else $error("no heat");
  property p_coolph; phaseMark == PH_COOL |-> !heatOn; endproperty
  a_coolph: assert property (p_coolph) else $error("heat in cool");
  property p_seq;
    phaseMark == PH_COOL |-> $past(phaseMark) inside {PH_HEAT, PH_COOL};
  endproperty
  a_seq: assert property (p_seq) else $error("cool not after heat");
  property p_cdn; countdown != 10'h000 |-> phaseMark == PH_HEAT; endproperty
  a_cdn: assert property (p_cdn) else $error("stray countdown");
  property p_cdec;
    phaseMark == PH_HEAT && $past(phaseMark) == PH_HEAT
      |-> countdown <= $past(countdown);
  endproperty
  a_cdec: assert property (p_cdec) else $error("countdown rose");
  // two sync flops plus the output registers, which follow the next state
  property p_abort;
    resetIn [*6] |-> phaseMark == PH_NONE && countdown == 10'h000;
  endproperty
  a_abort: assert property (p_abort) else $error("abort late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  property p_wait; psel && $rose(penable) |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
endmodule : hsct_monitor
bind hsct_top hsct_monitor u_mon (
  .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .resetIn(resetIn),
  .heatOn(heatOn), .phaseMark(phaseMark), .countdown(countdown),
  .outputRelay(outputRelay), .relayIcon(relayIcon));
`default_nettype wire

// File: tb/hsct_plc_model.sv
/* Machine control model driving the start and reset pins.
   Assumes the caller sequences launches; changes land after an edge. */
`timescale 1ns/10ps
`default_nettype none
module hsct_plc_model (
  // clocking
  input  wire logic clock,
  // pins
  output var  logic startIn,
  output var  logic resetIn
);
  initial begin
    startIn = 1'b0;
    resetIn = 1'b0;
  end
  // monitored mode only completes if start is held to the end
  task automatic launch(input int n);
    @(posedge clock);
    startIn <= 1'b1;
    repeat (n) @(posedge clock);
    startIn <= 1'b0;
  endtask : launch
  task automatic abort();
    @(posedge clock);
    resetIn <= 1'b1;
    repeat (8) @(posedge clock);
    resetIn <= 1'b0;
  endtask : abort
endmodule : hsct_plc_model
`default_nettype wire

// File: tb/hsct_tb_top.sv
/* Self-checking bench for the heatseal cycle timer.
   Assumes a tick of ten clocks; ce stays high throughout. */
`timescale 1ns/10ps
`default_nettype none
module hsct_tb_top
  import hsct_pkg::*;
;
  localparam int T = 10;
  logic clock = 1'b0, arst_n = 1'b0, ce = 1'b1, manualHeatKey = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [9:0] tempAct = 10'h000, tempSet = 10'h0C8, countdown;
  logic pready, pslverr, heatOn, outputRelay, relayIcon;
  logic [1:0] phaseMark;
  wire logic startIn, resetIn;
  int errCount = 0, totalChecks = 0;
  always #25 clock = ~clock;
  hsct_top #(.TICK_CYCLES(T)) uut (.clock(clock), .arst_n(arst_n),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .startIn(startIn), .resetIn(resetIn),
    .manualHeatKey(manualHeatKey), .tempAct(tempAct), .tempSet(tempSet),
    .heatOn(heatOn), .phaseMark(phaseMark), .countdown(countdown),
    .outputRelay(outputRelay), .relayIcon(relayIcon));
  hsct_plc_model plc (.clock(clock), .startIn(startIn), .resetIn(resetIn));
  //////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (errCount == 0 && totalChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      errCount++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  task automatic chkIn(input string nm, input int lo, input int hi,
                       input int g);
    totalChecks++;
    if (g < lo || g > hi) begin
      errCount++;
      $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask : chkIn
  // holds the request until pready is sampled high at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, 32'(pready));
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    xfer(1'b1, a, d, rd, er);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] rd;
    logic er;
    xfer(1'b0, a, 32'h0, rd, er);
    chk(nm, e, rd);
  endtask : rdc
  function automatic logic [31:0] mk(input logic [1:0] tm, input logic x,
      input logic [1:0] cm, input logic sot, input logic [2:0] rf);
    return {21'h0, rf, 1'b0, sot, cm, 1'b0, x, tm};
  endfunction : mk
  task automatic waitPh(input logic [1:0] ph, input int mx, output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (phaseMark !== ph && n < mx);
    chk("phase", 32'(ph), 32'(phaseMark));
  endtask : waitPh
  //////////////////////////////////////////////////////////////////////////
  task automatic tRegs();
    logic [31:0] rd;
    logic er;
    rdc("ctrl", OFS_CTRL, mk(TM_OFF, 1'b0, CM_ABS, 1'b1, RF_TEMP));
    rdc("delay", OFS_DELAY, 32'(RST_DELAY));
    rdc("seal", OFS_SEAL, 32'(RST_SEAL));
    rdc("cool", OFS_COOL, 32'(MIN_COOLABS));
    xfer(1'b0, 8'h18, 32'h0, rd, er);
    chk("unmapped err", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
    wr(OFS_DELAY, 32'hFF);
    rdc("delay max", OFS_DELAY, 32'(MAX_DELAY));
    wr(OFS_SEAL, 32'h3FF);
    rdc("seal max", OFS_SEAL, 32'(MAX_SEAL));
    wr(OFS_COOL, 32'h0);
    rdc("cool min", OFS_COOL, 32'(MIN_COOLABS));
    wr(OFS_CTRL, mk(TM_OFF, 1'b0, CM_REL, 1'b1, RF_TEMP));
    rdc("rel dflt", OFS_COOL, 32'(MIN_COOLREL));
    wr(OFS_COOL, 32'h80);
    rdc("rel max", OFS_COOL, 32'(MAX_COOLREL));
    wr(OFS_CTRL, mk(TM_OFF, 1'b0, CM_TIME, 1'b1, RF_TEMP));
    rdc("time dflt", OFS_COOL, 32'(RST_COOLTIME));
  endtask : tRegs
  task automatic tTimed();
    int n;
    wr(OFS_DELAY, 32'h2);
    wr(OFS_SEAL, 32'h3);
    wr(OFS_CTRL, mk(TM_ON, 1'b0, CM_TIME, 1'b0, RF_COOL));
    wr(OFS_COOL, 32'h3);
    fork
      plc.launch(3);
      waitPh(PH_HEAT, 200, n);
    join
    chkIn("delay", 2 * T, 2 * T + 8, n);
    waitPh(PH_COOL, 200, n);
    chkIn("heat", 3 * T - 2, 3 * T + 4, n);
    repeat (2) @(posedge clock);
    chk("relay cool", 32'h1, 32'(outputRelay));
    waitPh(PH_NONE, 200, n);
    chkIn("cool time", 3 * T - 5, 3 * T + 4, n);
    repeat (2) @(posedge clock);
    chk("relay end", 32'h0, 32'(outputRelay));
  endtask : tTimed
  task automatic tAbort(input logic [1:0] tm, input int hold);
    int n;
    wr(OFS_SEAL, 32'h64);
    wr(OFS_CTRL, mk(tm, 1'b0, CM_TIME, 1'b0, RF_START));
    fork
      plc.launch(hold);
      waitPh(PH_HEAT, 200, n);
    join
    if (tm == TM_ON) plc.abort();
    waitPh(PH_NONE, 40, n);
    chk("abort phase", 32'(PH_NONE), 32'(phaseMark));
    chk("abort heat", 32'h0, 32'(heatOn));
    chk("abort relay", 32'h0, 32'(outputRelay));
  endtask : tAbort
  task automatic tExt();
    int n, m;
    wr(OFS_DELAY, 32'h0);
    wr(OFS_CTRL, mk(TM_ON, 1'b1, CM_TIME, 1'b0, RF_COOL));
    wr(OFS_COOL, 32'h3);
    fork
      plc.launch(60);
      begin
        waitPh(PH_HEAT, 20, n);
        waitPh(PH_COOL, 100, m);
      end
    join
    chkIn("ext heat", 55, 64, m);
    waitPh(PH_NONE, 60, n);
  endtask : tExt
  task automatic tTemp();
    int n;
    wr(OFS_SEAL, 32'h3);
    wr(OFS_CTRL, mk(TM_ON, 1'b0, CM_ABS, 1'b1, RF_TEMP));
    wr(OFS_COOL, 32'd60);
    tempSet <= 10'd200;
    tempAct <= 10'd150;
    fork
      plc.launch(3);
      waitPh(PH_HEAT, 40, n);
    join
    repeat (40) @(posedge clock);
    chk("seal held", 32'h3, 32'(countdown));
    chk("relay early", 32'h0, 32'(outputRelay));
    tempAct <= 10'd190;
    waitPh(PH_COOL, 80, n);
    chk("relay temp", 32'h1, 32'(outputRelay));
    tempAct <= 10'd60;
    repeat (20) @(posedge clock);
    chk("abs hold", 32'(PH_COOL), 32'(phaseMark));
    tempAct <= 10'd59;
    waitPh(PH_NONE, 10, n);
    chk("abs end", 32'(PH_NONE), 32'(phaseMark));
  endtask : tTemp
  task automatic tRel();
    int n;
    wr(OFS_CTRL, mk(TM_ON, 1'b0, CM_REL, 1'b0, RF_EOC));
    wr(OFS_COOL, 32'd50);
    tempAct <= 10'd101;
    fork
      plc.launch(3);
      waitPh(PH_COOL, 100, n);
    join
    repeat (20) @(posedge clock);
    chk("rel hold", 32'(PH_COOL), 32'(phaseMark));
    tempAct <= 10'd100;
    waitPh(PH_NONE, 10, n);
    chk("rel end", 32'(PH_NONE), 32'(phaseMark));
    chk("eoc relay", 32'h1, 32'(outputRelay));
  endtask : tRel
  task automatic tKeys();
    manualHeatKey <= 1'b1;
    repeat (20) @(posedge clock);
    chk("key heat", 32'h1, 32'(heatOn));
    chk("key phase", 32'(PH_NONE), 32'(phaseMark));
    manualHeatKey <= 1'b0;
    wr(OFS_CTRL, mk(TM_OFF, 1'b0, CM_TIME, 1'b0, RF_COOL));
    fork
      plc.launch(20);
      repeat (30) @(posedge clock);
    join
    chk("off phase", 32'(PH_NONE), 32'(phaseMark));
  endtask : tKeys
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #(20000 * 50);
    errCount++;
    results();
  end
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    tRegs();
    tTimed();
    tAbort(TM_ON, 3);
    tAbort(TM_MON, 30);
    tExt();
    tTemp();
    tRel();
    tKeys();
    results();
  end
endmodule : hsct_tb_top
`default_nettype wire
